// File: smwts_float_track.v
`timescale 1ns/1ps
module smwts_float_track (
    input  wire       clock_i,
    input  wire       nrst_i,
    input  wire       load_i,
    input  wire [3:0] cycles_i,
    input  wire [2:0] cs_i,
    input  wire       consume_i,
    output wire [3:0] remain_o,
    output wire [2:0] owner_o
);
    reg [3:0] remain_reg;
    reg [2:0] owner_reg;
    reg       half_reg;

    // counts down internal traffic or not; one float cycle spans two half-step clocks
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            remain_reg <= 4'h0;
            owner_reg  <= 3'h0;
            half_reg   <= 1'b0;
        end else if (load_i) begin
            remain_reg <= cycles_i;
            owner_reg  <= cs_i;
            half_reg   <= 1'b0;
        end else if (consume_i) begin
            remain_reg <= 4'h0;
            half_reg   <= 1'b0;
        end else if (remain_reg != 4'h0) begin
            half_reg <= ~half_reg;
            if (half_reg)
                remain_reg <= remain_reg - 4'h1;
        end
    end

    assign remain_o = remain_reg;
    assign owner_o  = owner_reg;
endmodule

// File: smwts_mem_model.sv
`timescale 1ns/1ps
module smwts_mem_model #(
    parameter DATA_W = 16
) (
    input  wire              clock_i,
    input  wire [7:0]        chip_select_n_i,
    input  wire              rd_n_i,
    input  wire              wr_n_i,
    input  wire [DATA_W-1:0] data_i,
    input  wire [3:0]        stall_i,
    output reg               wait_n_o,
    output reg  [DATA_W-1:0] data_o
);
    reg [DATA_W-1:0] mem [0:7];
    reg [DATA_W-1:0] wbuf;
    reg [2:0]        sel;
    reg              strobe_q;
    reg              wr_q;
    integer          cnt;
    integer          k;
    initial begin
        for (k = 0; k < 8; k = k + 1) mem[k] = {DATA_W{1'b0}};
        sel = 3'h0;
        strobe_q = 1'b1;
        wr_q = 1'b1;
        cnt = 0;
        wait_n_o = 1'b1;
        data_o = {DATA_W{1'b0}};
        wbuf = {DATA_W{1'b0}};
    end
    always @(posedge clock_i) begin
        for (k = 0; k < 8; k = k + 1)
            if (!chip_select_n_i[k]) sel = k[2:0];
        // commit on strobe rise: a shortened select may not cover the whole pulse
        if (!wr_n_i) wbuf <= data_i;
        // only the end of a write strobe commits; the end of a read must not
        if (wr_n_i && !wr_q) mem[sel] <= wbuf;
        wr_q <= wr_n_i;
        strobe_q <= rd_n_i && wr_n_i;
        // released bus shows a toggling pattern, inverting the last value each cycle
        if (!rd_n_i || chip_select_n_i != 8'hff) data_o <= mem[sel];
        else data_o <= ~data_o;
        // wait only inside the pulse, one cycle after the strobe falls
        if (strobe_q && !(rd_n_i && wr_n_i)) cnt = stall_i;
        else if (cnt > 0) cnt = cnt - 1;
        wait_n_o <= !(cnt > 0 && !(rd_n_i && wr_n_i));
    end
endmodule

// File: smwts_regs.vh
`ifndef SMWTS_REGS_VH
`define SMWTS_REGS_VH
// per-chip-select configuration word field positions
`define SMWTS_WCNT_LSB     0
`define SMWTS_WCNT_MSB     6
`define SMWTS_WAITEN_BIT   7
`define SMWTS_FLOAT_LSB    8
`define SMWTS_FLOAT_MSB    11
`define SMWTS_EARLY_BIT    15
`define SMWTS_SHORT_LSB    16
`define SMWTS_SHORT_MSB    17
`define SMWTS_SETUP_LSB    24
`define SMWTS_SETUP_MSB    26
`define SMWTS_HOLD_LSB     28
`define SMWTS_HOLD_MSB     30
`define SMWTS_CFG_RESET    32'h00002000
`define SMWTS_SYNC_STAGES  2
`define SMWTS_CS_COUNT     8
`endif

// File: smwts_sequencer.v
// How it works
// - wait input low freezes pins, counters and state during the strobe pulse of an access
// - when wait returns high the interrupted access carries on to its end
// - wait input passes a two-flop synchroniser, two cycles late
// - wait low during the strobe pulse of an access also halts the core clock
// - after a read, float cycles of that select precede write or other memory
// - float cycles never stall internal accesses but keep counting meanwhile
// - no float cycles between same-memory reads or for internal accesses
// - one select-change wait state between memories unless another wait was inserted
// - early read protocol adds a wait state for write followed by read
// - no early read wait for read then write, same type, or internal
// - setup on the second memory removes the select-change wait state
// - float and setup overlap: only the larger of the two is inserted
// - reads: setup 1.5-7.5, hold 0-7, pulse 1.5-128.5 cycles
// - writes: setup 1.5-7.5, hold 0.5-7, pulse 1-128 cycles
// - nonzero shorten field trims chip select at both ends by 1-3 cycles
// - in shortened mode read data is caught as chip select rises
// - write strobe: half cycle at zero waits, one cycle per wait state
// - protocol bit 0 standard read mid-cycle, 1 early read at cycle start
// - shorten field 0 normal, 1-3 removes that many cycles at each end
`timescale 1ns/1ps
`include "smwts_regs.vh"
module smwts_sequencer #(
    parameter DATA_W = 16
) (
    input  wire              clock_i,
    input  wire              nrst_i,
    input  wire              req_i,
    input  wire              req_ext_i,
    input  wire              req_write_i,
    input  wire [2:0]        req_cs_i,
    input  wire [31:0]       req_cfg_i,
    input  wire [DATA_W-1:0] req_wdata_i,
    output wire              req_ready_o,
    output reg               done_o,
    output reg  [DATA_W-1:0] rdata_o,
    input  wire              wait_n_i,
    output wire              core_clk_hold_o,
    output reg  [7:0]        chip_select_n_o,
    output reg               rd_n_o,
    output reg               wr_n_o,
    output reg  [DATA_W-1:0] data_o,
    output reg               data_oe_o,
    input  wire [DATA_W-1:0] data_i
);
    // state codes; each phase is counted in half cycles so 0.5 steps are exact
    localparam ST_IDLE  = 3'h0;
    localparam ST_GAP   = 3'h1;
    localparam ST_SETUP = 3'h2;
    localparam ST_PULSE = 3'h3;
    localparam ST_HOLD  = 3'h4;

    reg  [2:0]        state_reg;
    reg  [2:0]        state_next;
    reg  [8:0]        cnt_reg;
    reg  [8:0]        cnt_next;
    reg  [2:0]        cs_reg;
    reg  [31:0]       cfg_reg;
    reg               write_reg;
    reg  [DATA_W-1:0] wdata_reg;
    reg               last_valid_reg;
    reg               last_write_reg;
    reg  [2:0]        last_cs_reg;
    reg  [8:0]        elapsed_reg;
    reg  [3:0]        float_load;
    reg               start_access;

    wire wait_n_sync;
    wire [3:0] float_remain;
    wire [2:0] float_owner;

    function [7:0] cfg_pulse;
        input [31:0] cfg;
        begin
            // pulse length in whole cycles; no waits means zero whole cycles
            if (cfg[`SMWTS_WAITEN_BIT])
                cfg_pulse = {1'b0, cfg[`SMWTS_WCNT_MSB:`SMWTS_WCNT_LSB]} + 8'h1;
            else
                cfg_pulse = 8'h0;
        end
    endfunction

    function [1:0] cfg_shorten;
        input [31:0] cfg;
        begin
            cfg_shorten = cfg[`SMWTS_SHORT_MSB:`SMWTS_SHORT_LSB];
        end
    endfunction

    smwts_wait_sync u_sync (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .wait_n_i (wait_n_i),
        .wait_n_o (wait_n_sync)
    );

    wire busy       = (state_reg != ST_IDLE);
    // freeze only inside the strobe pulse; setup and hold must not see wait
    wire frozen     = busy && !wait_n_sync && (state_reg == ST_PULSE);
    assign core_clk_hold_o = frozen;
    assign req_ready_o     = !busy;

    wire [2:0] req_setup = req_cfg_i[`SMWTS_SETUP_MSB:`SMWTS_SETUP_LSB];
    wire       req_early = req_cfg_i[`SMWTS_EARLY_BIT];
    wire       accept    = req_i && !busy;
    wire       other_mem = last_valid_reg && (last_cs_reg != req_cs_i);

    // gap cycles before a new external access, in whole cycles
    reg  [4:0]  gap_cycles;
    reg  [3:0]  eff_float;
    reg  [2:0]  eff_setup;
    reg         er_wait;
    reg         csc_wait;
    reg  [31:0] cfg_take;
    always @* begin
        eff_float = 4'h0;
        eff_setup = req_setup;
        er_wait   = 1'b0;
        csc_wait  = 1'b0;
        cfg_take  = req_cfg_i;
        // float applies to a write or a read of another memory
        if (float_remain != 4'h0 && (req_write_i || float_owner != req_cs_i))
            eff_float = float_remain;
        if (eff_float != 4'h0 && req_setup != 3'h0) begin
            if ({1'b0, eff_float} >= {2'b00, req_setup})
                eff_setup = 3'h0;
            else
                eff_float = 4'h0;
        end
        // the access itself runs with the trimmed setup
        cfg_take[`SMWTS_SETUP_MSB:`SMWTS_SETUP_LSB] = eff_setup;
        if (req_early && !req_write_i && last_valid_reg && last_write_reg)
            er_wait = 1'b1;
        if (other_mem && eff_float == 4'h0 && req_setup == 3'h0 && !er_wait)
            csc_wait = 1'b1;
        // five bits: full float plus the early read wait must not wrap to zero
        gap_cycles = {1'b0, eff_float} + {4'h0, er_wait} + {4'h0, csc_wait};
    end

    wire [7:0] pulse_c = cfg_pulse(cfg_reg);
    wire [2:0] setup_c = cfg_reg[`SMWTS_SETUP_MSB:`SMWTS_SETUP_LSB];
    wire [2:0] hold_c  = cfg_reg[`SMWTS_HOLD_MSB:`SMWTS_HOLD_LSB];
    wire       early_c = cfg_reg[`SMWTS_EARLY_BIT];
    wire [1:0] shrt_c  = cfg_shorten(cfg_reg);

    // half-cycle lengths of each phase
    reg [8:0] setup_h;
    reg [8:0] pulse_h;
    reg [8:0] hold_h;
    always @* begin
        if (setup_c != 3'h0)
            setup_h = {5'h0, setup_c, 1'b1};
        else if (!write_reg && early_c)
            setup_h = 9'h0;
        else
            setup_h = 9'h1;
        if (!write_reg && early_c)
            pulse_h = {pulse_c, 1'b0} + 9'h2;
        else if (!write_reg)
            pulse_h = {pulse_c, 1'b0} + 9'h1;
        else if (pulse_c == 8'h0)
            pulse_h = 9'h1;
        else
            pulse_h = {pulse_c, 1'b0};
        if (write_reg && hold_c == 3'h0)
            hold_h = 9'h1;
        else
            hold_h = {5'h0, hold_c, 1'b0};
    end

    always @* begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        float_load   = 4'h0;
        start_access = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (accept && req_ext_i) begin
                    if (gap_cycles != 5'h00) begin
                        state_next = ST_GAP;
                        cnt_next   = {3'h0, gap_cycles, 1'b0} - 9'h1;
                    end else begin
                        state_next   = ST_SETUP;
                        start_access = 1'b1;
                    end
                end
            end
            ST_GAP: begin
                // selects idle, bus released during gap cycles
                if (cnt_reg == 9'h0) begin
                    state_next   = ST_SETUP;
                    start_access = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 9'h1;
                end
            end
            ST_SETUP: begin
                if (cnt_reg + 9'h1 >= setup_h) begin
                    state_next = ST_PULSE;
                    cnt_next   = 9'h0;
                end else begin
                    cnt_next = cnt_reg + 9'h1;
                end
            end
            ST_PULSE: begin
                if (frozen) begin
                    cnt_next = cnt_reg;
                end else if (cnt_reg + 9'h1 >= pulse_h) begin
                    state_next = (hold_h == 9'h0) ? ST_IDLE : ST_HOLD;
                    cnt_next   = 9'h0;
                end else begin
                    cnt_next = cnt_reg + 9'h1;
                end
            end
            ST_HOLD: begin
                if (cnt_reg + 9'h1 >= hold_h) begin
                    state_next = ST_IDLE;
                    cnt_next   = 9'h0;
                end else begin
                    cnt_next = cnt_reg + 9'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next   = 9'h0;
            end
        endcase
        if (start_access)
            cnt_next = 9'h0;
        if (busy && state_next == ST_IDLE && !write_reg)
            float_load = cfg_reg[`SMWTS_FLOAT_MSB:`SMWTS_FLOAT_LSB];
    end

    wire read_end   = busy && !frozen && state_next == ST_IDLE && !write_reg;
    wire float_use  = accept && req_ext_i && (state_next != ST_IDLE);

    smwts_float_track u_float (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .load_i    (read_end),
        .cycles_i  (float_load),
        .cs_i      (cs_reg),
        .consume_i (float_use),
        .remain_o  (float_remain),
        .owner_o   (float_owner)
    );

    // half-cycle phase inside the access: elapsed counts half cycles since access start
    wire [8:0] elapsed_next = start_access ? 9'h0 :
                              (frozen ? elapsed_reg : elapsed_reg + 9'h1);
    wire in_access = (state_reg == ST_SETUP) || (state_reg == ST_PULSE) ||
                     (state_reg == ST_HOLD);
    // cfg_reg is stable for the whole access, so the length is taken combinationally
    wire [8:0] total_c = setup_h + pulse_h + hold_h;
    wire [8:0] trim   = {6'h0, shrt_c, 1'b0};
    wire       cs_on  = in_access && (elapsed_reg >= trim) &&
                        (elapsed_reg + trim < total_c);
    wire       rd_on  = (state_reg == ST_PULSE) && !write_reg;
    wire       wr_on  = (state_reg == ST_PULSE) && write_reg;
    wire       cs_rise = !chip_select_n_o[cs_reg] && !cs_on;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg       <= ST_IDLE;
            cnt_reg         <= 9'h0;
            cs_reg          <= 3'h0;
            cfg_reg         <= `SMWTS_CFG_RESET;
            write_reg       <= 1'b0;
            wdata_reg       <= {DATA_W{1'b0}};
            last_valid_reg  <= 1'b0;
            last_write_reg  <= 1'b0;
            last_cs_reg     <= 3'h0;
            elapsed_reg     <= 9'h0;
            done_o          <= 1'b0;
            rdata_o         <= {DATA_W{1'b0}};
            chip_select_n_o <= 8'hff;
            rd_n_o          <= 1'b1;
            wr_n_o          <= 1'b1;
            data_o          <= {DATA_W{1'b0}};
            data_oe_o       <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            elapsed_reg <= elapsed_next;
            done_o      <= 1'b0;
            if (accept && req_ext_i) begin
                cs_reg    <= req_cs_i;
                cfg_reg   <= cfg_take;
                write_reg <= req_write_i;
                wdata_reg <= req_wdata_i;
            end
            if (accept && !req_ext_i)
                done_o <= 1'b1;
            if (!frozen) begin
                // outputs held still while frozen
                chip_select_n_o <= 8'hff;
                if (cs_on)
                    chip_select_n_o[cs_reg] <= 1'b0;
                rd_n_o    <= !rd_on;
                wr_n_o    <= !wr_on;
                data_oe_o <= in_access && write_reg;
                data_o    <= wdata_reg;
            end
            if (!write_reg && busy && !frozen) begin
                if (shrt_c != 2'h0 ? cs_rise : (state_next == ST_IDLE))
                    rdata_o <= data_i;
            end
            if (busy && !frozen && state_next == ST_IDLE) begin
                done_o         <= 1'b1;
                last_valid_reg <= 1'b1;
                last_write_reg <= write_reg;
                last_cs_reg    <= cs_reg;
            end
        end
    end
endmodule

// File: smwts_sequencer_bench.sv
`timescale 1ns/1ps
`include "smwts_regs.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
    err_total = err_total + 1; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module smwts_sequencer_bench;
    localparam DW = 16;
    reg              clock_i = 1'b0;
    reg              nrst_i = 1'b0;
    reg              req_i = 1'b0;
    reg              req_ext_i = 1'b0;
    reg              req_write_i = 1'b0;
    reg  [2:0]       req_cs_i = 3'h0;
    reg  [31:0]      req_cfg_i = `SMWTS_CFG_RESET;
    reg  [DW-1:0]    req_wdata_i = 16'h0000;
    reg  [3:0]       stall = 4'h0;
    reg              rdy_s = 1'b0;
    reg              done_s = 1'b0;
    reg  [DW-1:0]    exp_mem [0:7];
    reg  [31:0]      cfg;
    wire             req_ready_o, done_o, wait_n_i, core_clk_hold_o, rd_n_o, wr_n_o, data_oe_o;
    wire [DW-1:0]    rdata_o, data_o, data_i;
    wire [7:0]       chip_select_n_o;
    integer          err_total = 0, checks = 0;
    integer          n, lat, it, i, cs, wr, ext, wcnt, shrt, early, flt, su, ho, smax, pul, hld;

    smwts_sequencer #(.DATA_W(DW)) DUT (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req_i),
        .req_ext_i(req_ext_i), .req_write_i(req_write_i), .req_cs_i(req_cs_i),
        .req_cfg_i(req_cfg_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .rdata_o(rdata_o), .wait_n_i(wait_n_i),
        .core_clk_hold_o(core_clk_hold_o), .chip_select_n_o(chip_select_n_o),
        .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .data_o(data_o), .data_oe_o(data_oe_o),
        .data_i(data_i));
    smwts_mem_model #(.DATA_W(DW)) partner (.clock_i(clock_i),
        .chip_select_n_i(chip_select_n_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
        .data_i(data_o), .stall_i(stall), .wait_n_o(wait_n_i), .data_o(data_i));

    always #2.5 clock_i = ~clock_i;
    // sample handshakes mid-cycle so the edge that acts on them sees settled values
    always @(negedge clock_i) begin
        rdy_s <= req_ready_o;
        done_s <= done_o;
    end

    task final_report;
        begin
            if (err_total == 0 && checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    task access;
        begin
            req_i <= 1'b1;
            n = 0;
            do begin @(posedge clock_i); n = n + 1; end while (rdy_s !== 1'b1 && n < 500);
            req_i <= 1'b0;
            if (n >= 500) err_total = err_total + 1;
            n = 0;
            do begin @(posedge clock_i); n = n + 1; end while (done_s !== 1'b1 && n < 2000);
            lat = n;
            if (n >= 2000) err_total = err_total + 1;
        end
    endtask

    initial begin
        #300000;
        err_total = err_total + 1;
        final_report;
    end

    initial begin
        for (i = 0; i < 8; i = i + 1) exp_mem[i] = 16'h0000;
        n = $urandom(46);
        repeat (16) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        for (it = 0; it < 300; it = it + 1) begin
            cs = $urandom % 8;
            wr = $urandom % 2;
            ext = ($urandom % 4) != 0;
            wcnt = 3 + $urandom % 8;
            shrt = $urandom % 4;
            if (shrt + 2 > wcnt) shrt = wcnt - 2;
            early = (shrt != 0) ? 0 : $urandom % 2;
            flt = $urandom % 16;
            // setup and hold only on plain standard-protocol selects
            su = (!early && !shrt) ? $urandom % 4 : 0;
            ho = (!early && !shrt) ? $urandom % 4 : 0;
            cfg = 32'h00000000;
            cfg[`SMWTS_WCNT_MSB:`SMWTS_WCNT_LSB] = wcnt[6:0];
            cfg[`SMWTS_WAITEN_BIT] = 1'b1;
            cfg[`SMWTS_FLOAT_MSB:`SMWTS_FLOAT_LSB] = flt[3:0];
            cfg[`SMWTS_EARLY_BIT] = early[0];
            cfg[`SMWTS_SHORT_MSB:`SMWTS_SHORT_LSB] = shrt[1:0];
            cfg[`SMWTS_SETUP_MSB:`SMWTS_SETUP_LSB] = su[2:0];
            cfg[`SMWTS_HOLD_MSB:`SMWTS_HOLD_LSB] = ho[2:0];
            stall <= (ext && wcnt >= 4 && $urandom % 3 == 0) ? 4'h4 : 4'h0;
            req_ext_i <= ext[0];
            req_write_i <= wr[0];
            req_cs_i <= cs[2:0];
            req_cfg_i <= cfg;
            req_wdata_i <= 16'($urandom);
            // phase lengths in half-step clocks, from the timing tables
            smax = (su != 0) ? 2 * su + 1 : 1;
            pul = 2 * (wcnt + 1) + (wr ? 0 : 1 + early);
            hld = (wr && ho == 0) ? 1 : 2 * ho;
            access;
            if (!ext) `CHK(lat, 1)
            if (ext) `CHK(lat >= 2 + pul + hld + stall, 1'b1)
            if (ext) `CHK(lat <= 1 + smax + pul + hld + stall + 34, 1'b1)
            if (ext && wr) exp_mem[cs] = req_wdata_i;
            if (ext && !wr) `CHK(rdata_o, exp_mem[cs])
        end
        repeat (20) @(posedge clock_i);
        final_report;
    end
endmodule

// File: smwts_sequencer_props.sv
`timescale 1ns/1ps
module smwts_seq_props (
    input wire       clock_i,
    input wire       nrst_i,
    input wire       req_i,
    input wire       req_ext_i,
    input wire       req_ready_o,
    input wire       done_o,
    input wire       wait_n_i,
    input wire       core_clk_hold_o,
    input wire [7:0] chip_select_n_o,
    input wire       rd_n_o,
    input wire       wr_n_o,
    input wire       data_oe_o
);
    wire strobe_low = !rd_n_o || !wr_n_o;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_int_take;
        req_i && req_ready_o && !req_ext_i;
    endsequence
    sequence s_idle_after;
        done_o && chip_select_n_o == 8'hff;
    endsequence
    a_wait_freeze: assert property (
        core_clk_hold_o |=> $stable({chip_select_n_o, rd_n_o, wr_n_o, data_oe_o}))
        else $error("pins moved while frozen");
    a_sync_delay: assert property (
        core_clk_hold_o |-> !$past(wait_n_i, 2)) else $error("freeze without synced wait");
    a_core_halt: assert property (
        core_clk_hold_o |-> !req_ready_o && strobe_low) else $error("freeze outside pulse");
    a_int_fast: assert property (
        s_int_take |=> done_o) else $error("internal access stalled");
    a_int_quiet: assert property (
        s_int_take |=> s_idle_after) else $error("internal access touched selects");
    a_one_select: assert property (
        $onehot0(~chip_select_n_o)) else $error("two selects active");
    a_bus_quiet: assert property (
        !rd_n_o |-> !data_oe_o) else $error("bus driven during read");
    a_strobe_excl: assert property (
        !(!rd_n_o && !wr_n_o)) else $error("read and write strobes together");
endmodule

bind smwts_sequencer smwts_seq_props u_props (.clock_i(clock_i), .nrst_i(nrst_i),
    .req_i(req_i), .req_ext_i(req_ext_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .wait_n_i(wait_n_i), .core_clk_hold_o(core_clk_hold_o),
    .chip_select_n_o(chip_select_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
    .data_oe_o(data_oe_o));

// File: smwts_wait_sync.v
`timescale 1ns/1ps
module smwts_wait_sync (
    input  wire clock_i,
    input  wire nrst_i,
    input  wire wait_n_i,
    output wire wait_n_o
);
    reg meta_reg;
    reg sync_reg;

    // two stages give the two-cycle latency of the wait request
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= wait_n_i;
            sync_reg <= meta_reg;
        end
    end

    assign wait_n_o = sync_reg;
endmodule
